// ==== src/ippsc_pkg.sv ====
`default_nettype none
package ippsc_pkg;
    localparam int WORD_W = 16;
    localparam int LONG_W = 32;
    localparam int PIPE_DEPTH = 3;
    // Stage indices, B enters first, D is fully decoded
    localparam int STG_B = 0;
    localparam int STG_C = 1;
    localparam int STG_D = 2;
    // Status word field positions and reset value
    localparam int PSW_S_BIT = 13;
    localparam int PSW_M_BIT = 12;
    localparam logic [15:0] PSW_RESET = 16'h2700;
    // Address-space codes
    localparam logic [2:0] ASC_USER_DATA = 3'h1;
    localparam logic [2:0] ASC_USER_PROG = 3'h2;
    localparam logic [2:0] ASC_SUP_DATA = 3'h5;
    localparam logic [2:0] ASC_SUP_PROG = 3'h6;
    localparam logic [2:0] ASC_CPU = 3'h7;
    // Bus access kinds requested by the sequencer
    typedef enum logic [1:0]
    {
        IPPSC_ACC_DATA = 2'b00,
        IPPSC_ACC_PROG = 2'b01,
        IPPSC_ACC_CPU = 2'b10
    } ippsc_acc_t;
    typedef enum logic [1:0]
    {
        IPPSC_ST_NORMAL = 2'b00,
        IPPSC_ST_EXCEPT = 2'b01,
        IPPSC_ST_HALTED = 2'b10,
        IPPSC_ST_STOPPED = 2'b11
    } ippsc_state_t;
endpackage
`default_nettype wire

// ==== src/ippsc_hold_reg.sv ====
`default_nettype none
module ippsc_hold_reg
    import ippsc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic flush,
    input wire logic load,
    input wire logic [LONG_W-2:0] load_addr,
    input wire logic [LONG_W-1:0] load_data,
    input wire logic load_fault,
    input wire logic [LONG_W-2:0] req_addr,
    output logic hit,
    output logic [WORD_W-1:0] low_word,
    output logic low_fault
);
    logic valid;
    logic [LONG_W-2:0] tag;
    logic [WORD_W-1:0] low;
    logic fault;
    // Only an odd-word request can hit: it asks for the low half of the held long word
    wire same_long = (req_addr[LONG_W-2:1] == tag[LONG_W-2:1]);
    assign hit = valid && req_addr[0] && same_long;
    assign low_word = low;
    assign low_fault = fault;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            valid <= 1'b0;
            tag <= '0;
            low <= '0;
            fault <= 1'b0;
        end
        else if (load)
        begin
            valid <= 1'b1;
            tag <= load_addr;
            low <= load_data[WORD_W-1:0];
            fault <= load_fault;
        end
        else if (flush)
        begin
            valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== src/ippsc_state_ctl.sv ====
`default_nettype none
module ippsc_state_ctl
    import ippsc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic exc_req,
    input wire logic handler_start,
    input wire logic fault_err,
    input wire logic stop_exec,
    input wire logic wake,
    output ippsc_state_t state,
    output logic enter_exc
);
    ippsc_state_t next_state;
    assign enter_exc = (state == IPPSC_ST_NORMAL || state == IPPSC_ST_STOPPED) && exc_req;
    always_comb
    begin
        next_state = state;
        unique case (state)
            IPPSC_ST_NORMAL:
            begin
                if (exc_req)
                    next_state = IPPSC_ST_EXCEPT;
                else if (stop_exec)
                    next_state = IPPSC_ST_STOPPED;
            end
            IPPSC_ST_EXCEPT:
            begin
                if (fault_err)
                    next_state = IPPSC_ST_HALTED;
                else if (handler_start)
                    next_state = IPPSC_ST_NORMAL;
            end
            IPPSC_ST_STOPPED:
            begin
                if (exc_req)
                    next_state = IPPSC_ST_EXCEPT;
                else if (wake)
                    next_state = IPPSC_ST_NORMAL;
            end
            IPPSC_ST_HALTED:
            begin
                next_state = IPPSC_ST_HALTED;
            end
        endcase
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state <= IPPSC_ST_NORMAL;
        else
            state <= next_state;
    end
endmodule
`default_nettype wire

// ==== src/ippsc_top.sv ====
// Operation
// - Three 16-bit stages B, C, D
// - Word decoded only when in stage D
// - Abnormal-termination flag travels with each word
// - Stages load only on sequencer prefetch
// - Pipe fed from 32-bit holding register; here it keeps only the low word, the high word goes straight to B
// - Even fetch loads long, high word B
// - Next odd fetch served from holding register
// - Holding register works with cache disabled
// - Request to all three; hit aborts bus
// - Sequencer starts prefetches, controls validation
// - One bus controller; sequencer stalls on accesses
// - Unless halted, normal or exception processing; here stop is a fourth, separate state
// - Listed exception causes enter exception processing
// - Exception ends at handler's first instruction
// - Fault during exception processing halts device
// - Only external reset leaves halted state
// - Stop gives normal state without bus cycles; here a separate stopped state, and a prefetch already in flight still finishes
// - Supervisor bit picks privilege and stack
// - Address-space code driven on every access
// - User privileged attempt traps to supervisor
// - Emulated register fault continues, not restarts
// - Exception entry saves status, sets supervisor
// - Three-bit code encodes target address space
`default_nettype none
module ippsc_top
    import ippsc_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Sequencer prefetch request, word address
    input wire logic PF_REQ,
    input wire logic [ADDR_W-2:0] PF_ADDR,
    input wire logic PF_VALIDATE,
    input wire logic D_CONSUME,
    // Instruction cache lookup
    output logic IC_REQ,
    input wire logic IC_ENABLE,
    input wire logic IC_HIT,
    input wire logic [LONG_W-1:0] IC_DATA,
    // Bus controller
    output logic BUS_REQ,
    output logic BUS_ABORT,
    output logic [2:0] ADDRESS_SPACE_CODE,
    input wire logic BUS_ACC_REQ,
    input wire logic [1:0] BUS_ACC_KIND,
    input wire logic BUS_DONE,
    input wire logic BUS_ERR,
    input wire logic [LONG_W-1:0] BUS_DATA,
    // Exception sources, faults, and handler, resume, stop and status word controls
    input wire logic INT_ACK,
    input wire logic TRACE_EXC,
    input wire logic TRAP_EXC,
    input wire logic COPRO_EXC,
    input wire logic OTHER_EXC,
    input wire logic ADDR_ERR,
    input wire logic PRIV_INSTR,
    input wire logic VREG_FAULT,
    input wire logic VREG_RESUME,
    input wire logic HANDLER_START,
    input wire logic STOP_EXEC,
    input wire logic STOP_WAKE,
    input wire logic PSW_WRITE,
    input wire logic [WORD_W-1:0] PSW_WDATA,
    // Pipe and state view
    output logic [WORD_W-1:0] STAGE_D_WORD,
    output logic STAGE_D_VALID,
    output logic STAGE_D_FAULT,
    output logic STAGE_B_VALID,
    output logic PF_DONE,
    output logic SEQ_STALL,
    output logic [WORD_W-1:0] PROC_STATUS_WORD,
    output logic [WORD_W-1:0] SAVED_STATUS_WORD,
    output logic SUPERVISOR,
    output logic SEL_SUPERVISOR_STACK,
    output logic PRIV_TRAP,
    output logic CONTINUE_PENDING,
    output logic [1:0] PROC_STATE
);
    // ******************************************************
    // Processing state
    // ******************************************************
    ippsc_state_t state;
    logic enter_exc;
    logic priv_trap;
    logic bus_fault;

    wire exc_cause = INT_ACK | TRACE_EXC | TRAP_EXC | BUS_ERR | COPRO_EXC | OTHER_EXC | priv_trap
                     | VREG_FAULT;
    wire in_exc = (state == IPPSC_ST_EXCEPT);
    wire halted = (state == IPPSC_ST_HALTED);
    wire stopped = (state == IPPSC_ST_STOPPED);
    assign bus_fault = BUS_ERR | ADDR_ERR;

    ippsc_state_ctl u_state
    (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .exc_req(exc_cause),
        .handler_start(HANDLER_START),
        .fault_err(bus_fault),
        .stop_exec(STOP_EXEC),
        .wake(STOP_WAKE),
        .state(state),
        .enter_exc(enter_exc)
    );
    assign PROC_STATE = state;

    // ******************************************************
    // Privilege and status word
    // ******************************************************
    logic [WORD_W-1:0] psw;
    logic [WORD_W-1:0] saved_psw;
    logic cont_pend;
    wire sup = psw[PSW_S_BIT];

    // A user attempt at a privileged resource becomes an exception cause
    assign priv_trap = PRIV_INSTR && !sup;
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            psw <= PSW_RESET;
            saved_psw <= '0;
        end
        else if (enter_exc)
        begin
            saved_psw <= psw;
            psw[PSW_S_BIT] <= 1'b1;
            if (INT_ACK)
                psw[PSW_M_BIT] <= 1'b0;
        end
        else if (PSW_WRITE && sup && !halted)
        begin
            psw <= PSW_WDATA;
        end
    end
    // Resume point kept so the faulted access continues instead of restarting
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
            cont_pend <= 1'b0;
        else if (enter_exc && VREG_FAULT)
            cont_pend <= 1'b1;
        else if (VREG_RESUME)
            cont_pend <= 1'b0;
    end
    assign PROC_STATUS_WORD = psw;
    assign SAVED_STATUS_WORD = saved_psw;
    assign SUPERVISOR = sup;
    assign SEL_SUPERVISOR_STACK = sup;
    assign PRIV_TRAP = priv_trap;
    assign CONTINUE_PENDING = cont_pend;

    // ******************************************************
    // Prefetch request and holding register
    // ******************************************************
    logic pf_busy;
    logic [ADDR_W-2:0] pf_addr;
    logic hold_hit;
    logic hold_match;
    logic [WORD_W-1:0] hold_low;
    logic hold_low_fault;
    logic fetch_ok;
    logic [LONG_W-1:0] fetch_data;
    logic fetch_fault;
    logic fetch_done;

    // No prefetch starts while stopped or halted; only one already in flight can still request the bus then
    wire pf_go = PF_REQ && !pf_busy && !halted && !stopped;
    wire cache_hit = IC_ENABLE && IC_HIT && !pf_addr[0];
    assign fetch_done = pf_busy && !hold_hit && (cache_hit || BUS_DONE);
    assign fetch_data = cache_hit ? IC_DATA : BUS_DATA;
    assign fetch_fault = !cache_hit && BUS_ERR;
    assign fetch_ok = fetch_done && !pf_addr[0];

    ippsc_hold_reg u_hold
    (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .flush(enter_exc),
        .load(fetch_ok),
        .load_addr(pf_addr),
        .load_data(fetch_data),
        .load_fault(fetch_fault),
        .req_addr(pf_addr),
        .hit(hold_match),
        .low_word(hold_low),
        .low_fault(hold_low_fault)
    );

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pf_busy <= 1'b0;
            pf_addr <= '0;
        end
        else if (enter_exc)
        begin
            pf_busy <= 1'b0;
        end
        else if (pf_go)
        begin
            pf_busy <= 1'b1;
            pf_addr <= PF_ADDR;
        end
        else if (hold_hit || fetch_done)
        begin
            pf_busy <= 1'b0;
        end
    end

    // Stale odd pf_addr must not hit again
    assign hold_hit = pf_busy && hold_match;
    // Presented to all three sources together; a hold hit kills the bus cycle
    assign IC_REQ = pf_busy && IC_ENABLE;
    assign BUS_REQ = (pf_busy && !cache_hit && !hold_hit) || (BUS_ACC_REQ && !stopped && !halted);
    assign BUS_ABORT = pf_busy && hold_hit;
    assign PF_DONE = hold_hit || fetch_done;
    assign SEQ_STALL = pf_busy || (BUS_ACC_REQ && !BUS_DONE);

    // ******************************************************
    // Address-space code
    // ******************************************************
    ippsc_acc_t acc;
    assign acc = pf_busy ? IPPSC_ACC_PROG : ippsc_acc_t'(BUS_ACC_KIND);

    wire sup_ref = sup || in_exc;
    wire [2:0] asc_prog = sup_ref ? ASC_SUP_PROG : ASC_USER_PROG;
    wire [2:0] asc_data = sup_ref ? ASC_SUP_DATA : ASC_USER_DATA;
    assign ADDRESS_SPACE_CODE = (acc == IPPSC_ACC_CPU) ? ASC_CPU :
                                (acc == IPPSC_ACC_PROG) ? asc_prog : asc_data;

    // ******************************************************
    // Instruction pipe B -> C -> D
    // ******************************************************
    logic [WORD_W-1:0] stg_word [PIPE_DEPTH];
    logic [PIPE_DEPTH-1:0] stg_valid;
    logic [PIPE_DEPTH-1:0] stg_fault;
    logic [PIPE_DEPTH-1:0] stg_move;

    wire new_word = hold_hit || fetch_done;
    wire [WORD_W-1:0] in_word = hold_hit ? hold_low : fetch_data[LONG_W-1:WORD_W];
    wire in_fault = hold_hit ? hold_low_fault : fetch_fault;
    wire in_word_sel = hold_hit ? 1'b1 : !pf_addr[0];
    // An odd fetch that missed the holding register takes the low half of the long word
    wire [WORD_W-1:0] stage_in = in_word_sel ? in_word : fetch_data[WORD_W-1:0];
    // Stage D empties on consume; C and D advance only into an empty or emptying slot, B loads on every validated new word
    assign stg_move[STG_D] = stg_valid[STG_C] && (!stg_valid[STG_D] || D_CONSUME);
    assign stg_move[STG_C] = stg_valid[STG_B] && (!stg_valid[STG_C] || stg_move[STG_D]);
    assign stg_move[STG_B] = new_word && PF_VALIDATE;
    genvar gi;
    generate
        for (gi = 0; gi < PIPE_DEPTH; gi++)
        begin : g_stage
            logic next_valid;
            logic fill;
            logic drain;
            assign fill = stg_move[gi];
            assign drain = (gi == STG_D) ? D_CONSUME : stg_move[(gi + 1) % PIPE_DEPTH];
            assign next_valid = fill | (stg_valid[gi] & !drain);
            always_ff @(posedge CORE_CLK or negedge RSTN)
            begin
                if (!RSTN)
                begin
                    stg_valid[gi] <= 1'b0;
                    stg_word[gi] <= '0;
                    stg_fault[gi] <= 1'b0;
                end
                else if (enter_exc)
                begin
                    stg_valid[gi] <= 1'b0;
                end
                else
                begin
                    stg_valid[gi] <= next_valid;
                    if (fill)
                    begin
                        if (gi == STG_B)
                        begin
                            stg_word[gi] <= stage_in;
                            stg_fault[gi] <= in_fault;
                        end
                        else
                        begin
                            stg_word[gi] <= stg_word[(gi + PIPE_DEPTH - 1) % PIPE_DEPTH];
                            stg_fault[gi] <= stg_fault[(gi + PIPE_DEPTH - 1) % PIPE_DEPTH];
                        end
                    end
                end
            end
        end
    endgenerate
    // Only stage D counts as decoded
    assign STAGE_D_WORD = stg_word[STG_D];
    assign STAGE_D_VALID = stg_valid[STG_D];
    assign STAGE_D_FAULT = stg_fault[STG_D];
    assign STAGE_B_VALID = stg_valid[STG_B];

    // ******************************************************
    // Checks
    // ******************************************************
    sequence s_fault_in_exc;
        in_exc && bus_fault;
    endsequence
    sequence s_even_to_b;
        fetch_ok && PF_VALIDATE && !enter_exc;
    endsequence
    sequence s_hit_to_b;
        hold_hit && PF_VALIDATE && !enter_exc;
    endsequence
    AST_HALT_ON_FAULT: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        s_fault_in_exc |=> halted) else $error("fault in exception did not halt");
    AST_HALT_STICKY: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        halted |=> halted) else $error("left halted without reset");
    AST_SUP_ON_ENTRY: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        enter_exc |=> sup && saved_psw == $past(psw)) else $error("entry did not save and set S");
    AST_ABORT_ON_HIT: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        hold_hit && pf_busy |-> BUS_ABORT && !BUS_REQ) else $error("hold hit did not abort bus");
    AST_STOP_NO_BUS: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        stopped && !pf_busy |-> !BUS_REQ) else $error("bus cycle while stopped");
    AST_FLUSH: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        enter_exc |=> stg_valid == '0) else $error("flush left valid stage");
    AST_C_TO_D: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        stg_move[STG_D] && !enter_exc |=> stg_word[STG_D] == $past(stg_word[STG_C])
        && stg_fault[STG_D] == $past(stg_fault[STG_C])) else $error("word or flag lost C to D");
    AST_USER_ASC: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !sup && !in_exc && pf_busy |-> ADDRESS_SPACE_CODE == ASC_USER_PROG) else $error("bad user code");
    AST_PRIV_TRAP: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        PRIV_INSTR && !sup && state == IPPSC_ST_NORMAL |=> in_exc) else $error("no trap on user priv");
    AST_NO_SPEC: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !pf_busy |=> !$rose(stg_valid[STG_B]) || $past(pf_busy)) else $error("speculative load");
    AST_EVEN_TO_B: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        s_even_to_b |=> stg_word[STG_B] == $past(in_word)) else $error("high word not in B");
    AST_HIT_TO_B: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        s_hit_to_b |=> stg_word[STG_B] == $past(hold_low)) else $error("held low word not in B");
endmodule
`default_nettype wire

// ==== verif/ippsc_far_model.sv ====
`default_nettype none
module ippsc_far_model
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [30:0] addr,
    input wire logic ic_req,
    input wire logic hit_mode,
    input wire logic bus_req,
    input wire logic bus_abort,
    input wire logic err_mode,
    input wire logic [3:0] delay,
    output logic ic_hit,
    output logic [31:0] ic_data,
    output logic bus_done,
    output logic bus_err,
    output logic [31:0] bus_data
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // Cache lookup and bus controller
    // ************************************************************
    logic [3:0] cnt;
    logic [31:0] lng;
    assign lng = {addr[16:1] ^ 16'h5a00, addr[16:1] ^ 16'ha500};
    assign ic_hit = ic_req & hit_mode;
    // A miss shows the inverse long, so a stale read can never match
    assign ic_data = ic_hit ? lng : ~lng;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt <= 4'h0;
            bus_done <= 1'b0;
            bus_err <= 1'b0;
            bus_data <= 32'h0;
        end
        else
        begin
            bus_done <= 1'b0;
            bus_err <= 1'b0;
            // Idle data toggles every cycle: the bus is not driven then
            bus_data <= ~bus_data;
            if (!bus_req || bus_abort || bus_done || bus_err)
                cnt <= 4'h0;
            else if (cnt == delay)
            begin
                cnt <= 4'h0;
                if (err_mode)
                    bus_err <= 1'b1;
                else
                begin
                    bus_done <= 1'b1;
                    bus_data <= lng;
                end
            end
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`default_nettype none
module testbench
    import ippsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic CORE_CLK = 0, RSTN = 0, PF_REQ = 0, PF_VALIDATE = 0, D_CONSUME = 0, IC_ENABLE = 0;
    logic BUS_ACC_REQ = 0, ADDR_ERR = 0, VREG_RESUME = 0, HANDLER_START = 0, STOP_EXEC = 0;
    logic STOP_WAKE = 0, PSW_WRITE = 0, hit_mode = 0, err_mode = 0;
    logic [30:0] PF_ADDR = 31'h0;
    logic [1:0] BUS_ACC_KIND = 2'h0;
    logic [15:0] PSW_WDATA = 16'h0;
    logic [6:0] exc = 7'h0;
    logic [3:0] delay = 4'h0;
    logic INT_ACK, TRACE_EXC, TRAP_EXC, COPRO_EXC, OTHER_EXC, PRIV_INSTR, VREG_FAULT;
    logic IC_REQ, IC_HIT, BUS_REQ, BUS_ABORT, BUS_DONE, BUS_ERR, STAGE_D_VALID, STAGE_D_FAULT;
    logic STAGE_B_VALID, PF_DONE, SEQ_STALL, SUPERVISOR, SEL_SUPERVISOR_STACK, PRIV_TRAP, CONTINUE_PENDING;
    logic [31:0] IC_DATA, BUS_DATA;
    logic [2:0] ADDRESS_SPACE_CODE;
    logic [15:0] STAGE_D_WORD, PROC_STATUS_WORD, SAVED_STATUS_WORD;
    logic [1:0] PROC_STATE;
    logic [2:0] ea [6];
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    assign {VREG_FAULT, PRIV_INSTR, OTHER_EXC, COPRO_EXC, TRAP_EXC, TRACE_EXC, INT_ACK} = exc;
    always #12.5 CORE_CLK = ~CORE_CLK;
    ippsc_top #(.ADDR_W(32)) ippsc_top_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PF_REQ(PF_REQ),
        .PF_ADDR(PF_ADDR), .PF_VALIDATE(PF_VALIDATE), .D_CONSUME(D_CONSUME), .IC_REQ(IC_REQ),
        .IC_ENABLE(IC_ENABLE), .IC_HIT(IC_HIT), .IC_DATA(IC_DATA), .BUS_REQ(BUS_REQ), .BUS_ABORT(BUS_ABORT),
        .ADDRESS_SPACE_CODE(ADDRESS_SPACE_CODE), .BUS_ACC_REQ(BUS_ACC_REQ), .BUS_ACC_KIND(BUS_ACC_KIND),
        .BUS_DONE(BUS_DONE), .BUS_ERR(BUS_ERR), .BUS_DATA(BUS_DATA), .INT_ACK(INT_ACK),
        .TRACE_EXC(TRACE_EXC), .TRAP_EXC(TRAP_EXC), .COPRO_EXC(COPRO_EXC), .OTHER_EXC(OTHER_EXC),
        .ADDR_ERR(ADDR_ERR), .PRIV_INSTR(PRIV_INSTR), .VREG_FAULT(VREG_FAULT), .VREG_RESUME(VREG_RESUME),
        .HANDLER_START(HANDLER_START), .STOP_EXEC(STOP_EXEC), .STOP_WAKE(STOP_WAKE), .PSW_WRITE(PSW_WRITE),
        .PSW_WDATA(PSW_WDATA), .STAGE_D_WORD(STAGE_D_WORD), .STAGE_D_VALID(STAGE_D_VALID),
        .STAGE_D_FAULT(STAGE_D_FAULT), .STAGE_B_VALID(STAGE_B_VALID), .PF_DONE(PF_DONE),
        .SEQ_STALL(SEQ_STALL), .PROC_STATUS_WORD(PROC_STATUS_WORD), .SAVED_STATUS_WORD(SAVED_STATUS_WORD),
        .SUPERVISOR(SUPERVISOR), .SEL_SUPERVISOR_STACK(SEL_SUPERVISOR_STACK), .PRIV_TRAP(PRIV_TRAP),
        .CONTINUE_PENDING(CONTINUE_PENDING), .PROC_STATE(PROC_STATE));
    ippsc_far_model ippsc_far_model_i (.clk(CORE_CLK), .rstn(RSTN), .addr(PF_ADDR), .ic_req(IC_REQ),
        .hit_mode(hit_mode), .bus_req(BUS_REQ), .bus_abort(BUS_ABORT), .err_mode(err_mode),
        .delay(delay), .ic_hit(IC_HIT), .ic_data(IC_DATA), .bus_done(BUS_DONE), .bus_err(BUS_ERR),
        .bus_data(BUS_DATA));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge CORE_CLK)
    begin
        cyc++;
        if (cyc >= 5000)
        begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    function automatic logic [15:0] wexp(input logic [30:0] a);
        return a[0] ? (a[16:1] ^ 16'ha500) : (a[16:1] ^ 16'h5a00);
    endfunction
    task automatic do_reset();
        RSTN = 1'b0;
        tick(6);
        RSTN = 1'b1;
        chk(PROC_STATE, IPPSC_ST_NORMAL);
        chk(PROC_STATUS_WORD, PSW_RESET);
        chk(SUPERVISOR, 1'b1);
        chk(STAGE_D_VALID, 1'b0);
        chk(STAGE_B_VALID, 1'b0);
    endtask
    // Taken on the first edge, so dropped right after
    task automatic fetch(input logic [30:0] a, input logic v, input int mode, input int en);
        int n = 0;
        tick(1);
        PF_REQ = 1'b1;
        PF_ADDR = a;
        PF_VALIDATE = v;
        tick(1);
        PF_REQ = 1'b0;
        while (PF_DONE !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        chk(16'(n), 16'(en));
        chk(IC_REQ, IC_ENABLE);
        if (mode != 1)
            chk(BUS_ABORT, mode == 2);
        tick(1);
        PF_VALIDATE = 1'b0;
    endtask
    task automatic pop(input logic [15:0] w);
        int n = 0;
        while (STAGE_D_VALID !== 1'b1 && n < 8)
        begin
            tick(1);
            n++;
        end
        chk(STAGE_D_WORD, w);
        chk(STAGE_D_FAULT, 1'b0);
        pulse(D_CONSUME);
    endtask
    task automatic acc(input logic [1:0] k, input logic [2:0] e);
        int n = 0;
        BUS_ACC_REQ = 1'b1;
        BUS_ACC_KIND = k;
        #1;
        chk(ADDRESS_SPACE_CODE, e);
        chk(SEQ_STALL, 1'b1);
        while (BUS_DONE !== 1'b1 && BUS_ERR !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        tick(1);
        BUS_ACC_REQ = 1'b0;
        tick(1);
    endtask
    task automatic set_psw(input logic [15:0] v);
        PSW_WRITE = 1'b1;
        PSW_WDATA = v;
        tick(1);
        PSW_WRITE = 1'b0;
        tick(1);
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_pipe();
        delay = 4'h3;
        fetch(31'h200, 1'b1, 0, 4);
        delay = 4'h0;
        fetch(31'h201, 1'b1, 2, 0);
        fetch(31'h203, 1'b1, 0, 1);
        tick(2);
        chk(STAGE_B_VALID, 1'b1);
        chk(STAGE_D_VALID, 1'b1);
        pop(wexp(31'h200));
        pop(wexp(31'h201));
        pop(wexp(31'h203));
        tick(1);
        chk(STAGE_D_VALID, 1'b0);
    endtask
    task automatic t_cache();
        IC_ENABLE = 1'b1;
        hit_mode = 1'b1;
        // Slow bus so the abandoned bus cycle never completes
        delay = 4'h3;
        fetch(31'h100, 1'b1, 1, 0);
        hit_mode = 1'b0;
        fetch(31'h101, 1'b1, 2, 0);
        pop(wexp(31'h100));
        pop(wexp(31'h101));
        IC_ENABLE = 1'b0;
        delay = 4'h0;
    endtask
    task automatic t_novalid();
        fetch(31'h300, 1'b0, 0, 1);
        tick(2);
        chk(STAGE_B_VALID, 1'b0);
        chk(STAGE_D_VALID, 1'b0);
    endtask
    task automatic t_exc();
        for (int i = 0; i < 7; i++)
        begin
            set_psw(16'h1000);
            fetch(31'h400, 1'b1, 0, 1);
            tick(2);
            chk(SEL_SUPERVISOR_STACK, 1'b0);
            exc = 7'h0;
            exc[i] = 1'b1;
            #1;
            if (i == 5)
                chk(PRIV_TRAP, 1'b1);
            tick(1);
            exc = 7'h0;
            chk(PROC_STATE, IPPSC_ST_EXCEPT);
            chk(SAVED_STATUS_WORD, 16'h1000);
            chk(SUPERVISOR, 1'b1);
            chk(PROC_STATUS_WORD[PSW_M_BIT], i != 0);
            chk(STAGE_D_VALID, 1'b0);
            if (i == 6)
                chk(CONTINUE_PENDING, 1'b1);
            tick(3);
            chk(PROC_STATE, IPPSC_ST_EXCEPT);
            pulse(HANDLER_START);
            chk(PROC_STATE, IPPSC_ST_NORMAL);
            if (i == 6)
            begin
                pulse(VREG_RESUME);
                chk(CONTINUE_PENDING, 1'b0);
            end
        end
    endtask
    task automatic t_asc();
        ea = '{ASC_SUP_DATA, ASC_SUP_PROG, ASC_CPU, ASC_USER_DATA, ASC_USER_PROG, ASC_CPU};
        for (int i = 0; i < 6; i++)
        begin
            if (i == 3)
                set_psw(16'h0000);
            acc(2'(i % 3), ea[i]);
        end
        set_psw(16'h2000);
        chk(PROC_STATUS_WORD, 16'h0000);
    endtask
    task automatic t_stop();
        pulse(STOP_EXEC);
        chk(PROC_STATE, IPPSC_ST_STOPPED);
        PF_REQ = 1'b1;
        PF_ADDR = 31'h500;
        tick(2);
        chk(BUS_REQ, 1'b0);
        chk(PF_DONE, 1'b0);
        PF_REQ = 1'b0;
        pulse(STOP_WAKE);
        chk(PROC_STATE, IPPSC_ST_NORMAL);
    endtask
    task automatic t_halt();
        for (int k = 0; k < 2; k++)
        begin
            exc = 7'h4;
            tick(1);
            exc = 7'h0;
            chk(PROC_STATE, IPPSC_ST_EXCEPT);
            err_mode = (k == 1);
            if (k == 0)
                pulse(ADDR_ERR);
            else
                acc(2'h0, ASC_SUP_DATA);
            err_mode = 1'b0;
            chk(PROC_STATE, IPPSC_ST_HALTED);
            pulse(HANDLER_START);
            pulse(STOP_WAKE);
            chk(PROC_STATE, IPPSC_ST_HALTED);
            do_reset();
        end
    endtask
    initial
    begin
        do_reset();
        t_pipe();
        t_cache();
        t_novalid();
        t_exc();
        t_asc();
        t_stop();
        t_halt();
        test_done();
    end
endmodule
`default_nettype wire
